// File: rtl/zdis_regs.vh
`ifndef ZDIS_REGS_VH
`define ZDIS_REGS_VH
// register byte addresses
`define ZDIS_ADDR_FORCE_LO      16'h013F
`define ZDIS_ADDR_FORCE_HI      16'h0140
`define ZDIS_ADDR_ZD_CTRL       16'h0487
`define ZDIS_ADDR_SRC_CTRL      16'h052A
// field positions
`define ZDIS_ZD_EN_BIT          0
`define ZDIS_ZD_SEL_LSB         1
`define ZDIS_ZD_SEL_MSB         2
`define ZDIS_SRC_BIT            0
// reset values
`define ZDIS_FORCE_RST          12'h000
`define ZDIS_ZD_EN_RST          1'h0
`define ZDIS_ZD_SEL_RST         2'h0
`define ZDIS_SRC_RST            1'h0
// force value that keeps the feedback output on
`define ZDIS_FORCE_FEEDBACK     12'h800
// reserved choice, the feedback input
`define ZDIS_SEL_RESERVED       2'h3
// governing source codes
`define ZDIS_GOV_PINS           2'h0
`define ZDIS_GOV_NORMAL_REG     2'h1
`define ZDIS_GOV_ZD_REG         2'h2
`define ZDIS_GOV_AUTO           2'h3
`endif

// File: rtl/zdis_sel_decode.v
`timescale 1ns/100ps
// turns a two-bit choice into a one-hot reference select
module zdis_sel_decode
(
    choice,
    valid,
    onehot
);
    input  wire [1:0] choice;
    input  wire       valid;
    output wire [2:0] onehot;

    // one enable per usable reference; reserved code selects none
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_ref
            localparam [1:0] CODE = i;
            assign onehot[i] = valid & (choice == CODE);
        end
    endgenerate
endmodule

// File: rtl/zdis_top.v
// Behaviour
// R1: zero-delay only when enable bit set, default off
// R2: zero-delay opens internal feedback path
// R3: zero-delay choice manual: pins or register field
// R4: source bit picks pins (0) or register (1)
// R5: register mode ignores normal select register
// R6: field decodes 0,1,2 to inputs; 3 reserved
// R7: field applies only when enable and source set
// R8: no hitless switching during zero-delay
// R9: force 0x000 none, 0x800 keeps feedback output
// R10: auto off: pins or register per bits
// R11: auto switching enable overrides pins and both registers for the choice; code overrides only the choice, not zero-delay
// R12: software avoids reserved field value three
`timescale 1ns/100ps
`include "zdis_regs.vh"
module zdis_top
(
    clk_sys,
    reset,
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata,
    reg_rdata,
    input_choice_pin_hi,
    input_choice_pin_lo,
    normal_input_choice,
    auto_input_switch_enable,
    auto_input_choice,
    zero_delay_operation,
    internal_feedback_open,
    hitless_switch_allow,
    ref_select,
    ref_select_valid,
    governing_source,
    feedback_output_force,
    output_force_mask
);
    // clock and reset
    input  wire        clk_sys;
    input  wire        reset;

    // byte register port
    input  wire        reg_wr;
    input  wire        reg_rd;
    input  wire [15:0] reg_addr;
    input  wire [7:0]  reg_wdata;
    output reg  [7:0]  reg_rdata;

    // select pins and outside selectors
    input  wire        input_choice_pin_hi;
    input  wire        input_choice_pin_lo;
    input  wire [1:0]  normal_input_choice;
    input  wire        auto_input_switch_enable;
    input  wire [1:0]  auto_input_choice;

    // control outputs
    output reg         zero_delay_operation;
    output reg         internal_feedback_open;
    output reg         hitless_switch_allow;
    output reg  [2:0]  ref_select;
    output reg         ref_select_valid;
    output reg  [1:0]  governing_source;
    output reg         feedback_output_force;
    output reg  [11:0] output_force_mask;

    // configuration registers
    reg  [11:0] output_force_on_r;
    reg         zero_delay_enable_r;
    reg  [1:0]  zero_delay_input_choice_r;
    reg         input_choice_source_r;

    reg  [1:0]  gov_nxt;
    reg  [1:0]  choice_nxt;
    reg         valid_nxt;
    reg  [7:0]  rdata_nxt;
    wire [2:0]  onehot;
    wire [1:0]  pin_choice;

    // the two select pins form the manual choice code
    assign pin_choice = {input_choice_pin_hi, input_choice_pin_lo};

    // force field, each byte written on its own
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            output_force_on_r <= `ZDIS_FORCE_RST;
        end
        else if (reg_wr && reg_addr == `ZDIS_ADDR_FORCE_LO)
        begin
            output_force_on_r[7:0] <= reg_wdata;
        end
        else if (reg_wr && reg_addr == `ZDIS_ADDR_FORCE_HI)
        begin
            output_force_on_r[11:8] <= reg_wdata[3:0]; // upper bits dropped
        end
    end

    // zero-delay enable, off after reset
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            zero_delay_enable_r <= `ZDIS_ZD_EN_RST; // R1
        end
        else if (reg_wr && reg_addr == `ZDIS_ADDR_ZD_CTRL)
        begin
            zero_delay_enable_r <= reg_wdata[`ZDIS_ZD_EN_BIT]; // R1
        end
    end

    // zero-delay choice field shares the enable byte
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            zero_delay_input_choice_r <= `ZDIS_ZD_SEL_RST; // R6
        end
        else if (reg_wr && reg_addr == `ZDIS_ADDR_ZD_CTRL)
        begin
            zero_delay_input_choice_r <= reg_wdata[`ZDIS_ZD_SEL_MSB:`ZDIS_ZD_SEL_LSB];
        end
    end

    // choice source bit: pins or register field
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            input_choice_source_r <= `ZDIS_SRC_RST; // R4
        end
        else if (reg_wr && reg_addr == `ZDIS_ADDR_SRC_CTRL)
        begin
            input_choice_source_r <= reg_wdata[`ZDIS_SRC_BIT]; // R4
        end
    end

    // read data mux; unmapped and reserved bits read zero
    always @*
    begin
        rdata_nxt = 8'h00;
        if (reg_addr == `ZDIS_ADDR_FORCE_LO)
            rdata_nxt = output_force_on_r[7:0];
        else if (reg_addr == `ZDIS_ADDR_FORCE_HI)
            rdata_nxt = {4'h0, output_force_on_r[11:8]};
        else if (reg_addr == `ZDIS_ADDR_ZD_CTRL)
            rdata_nxt = {5'h00, zero_delay_input_choice_r, zero_delay_enable_r};
        else if (reg_addr == `ZDIS_ADDR_SRC_CTRL)
            rdata_nxt = {7'h00, input_choice_source_r};
        else
            rdata_nxt = 8'h00;
    end

    // read data taken on the strobe, held until the next read
    always @(posedge clk_sys)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
    end

    // which source governs the reference choice
    always @*
    begin
        gov_nxt = `ZDIS_GOV_PINS;
        if (auto_input_switch_enable)
            gov_nxt = `ZDIS_GOV_AUTO; // R11
        else if (!input_choice_source_r)
            gov_nxt = `ZDIS_GOV_PINS; // R10
        else if (zero_delay_enable_r)
            gov_nxt = `ZDIS_GOV_ZD_REG; // R7
        else
            gov_nxt = `ZDIS_GOV_NORMAL_REG; // R10
    end

    // choice code taken from the governing source
    always @*
    begin
        choice_nxt = pin_choice;
        if (gov_nxt == `ZDIS_GOV_AUTO)
            choice_nxt = auto_input_choice; // R11
        else if (gov_nxt == `ZDIS_GOV_ZD_REG)
            choice_nxt = zero_delay_input_choice_r; // R5
        else if (gov_nxt == `ZDIS_GOV_NORMAL_REG)
            choice_nxt = normal_input_choice;
        else
            choice_nxt = pin_choice; // R3
    end

    // reserved code is the feedback input: no valid reference
    always @*
    begin
        valid_nxt = 1'b1;
        if (choice_nxt == `ZDIS_SEL_RESERVED)
            valid_nxt = 1'b0; // R6
    end

    zdis_sel_decode u_dec
    (
        .choice (choice_nxt),
        .valid  (valid_nxt),
        .onehot (onehot)
    );

    // zero-delay state, one cycle behind the enable bit
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            zero_delay_operation <= 1'b0;
        end
        else
        begin
            zero_delay_operation <= zero_delay_enable_r; // R1
        end
    end

    // internal loop opened while in zero-delay
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            internal_feedback_open <= 1'b0;
        end
        else
        begin
            internal_feedback_open <= zero_delay_enable_r; // R2
        end
    end

    // hitless switching barred in zero-delay
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            hitless_switch_allow <= 1'b1;
        end
        else
        begin
            hitless_switch_allow <= ~zero_delay_enable_r; // R8
        end
    end

    // one-hot reference select, input 0 after reset
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ref_select <= 3'h1;
        end
        else
        begin
            ref_select <= onehot; // R6
        end
    end

    // low when the chosen code names no reference
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ref_select_valid <= 1'b1;
        end
        else
        begin
            ref_select_valid <= valid_nxt; // R6
        end
    end

    // governing source code for the outside
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            governing_source <= `ZDIS_GOV_PINS;
        end
        else
        begin
            governing_source <= gov_nxt; // R10
        end
    end

    // feedback output kept on by the top force bit
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            feedback_output_force <= 1'b0;
        end
        else
        begin
            feedback_output_force <= output_force_on_r[11]; // R9
        end
    end

    // full force field copied out
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            output_force_mask <= `ZDIS_FORCE_RST;
        end
        else
        begin
            output_force_mask <= output_force_on_r; // R9
        end
    end
endmodule

// File: test/zdis_props.sv
`timescale 1ns/100ps
// watches the control outputs of the zero-delay select block
module zdis_props (
    input wire logic        clk_sys, reset, reg_wr, reg_rd, input_choice_pin_hi,
    input wire logic        input_choice_pin_lo, auto_input_switch_enable, zero_delay_operation,
    input wire logic        internal_feedback_open, hitless_switch_allow, ref_select_valid,
    input wire logic        feedback_output_force,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    input wire logic [1:0]  normal_input_choice, auto_input_choice, governing_source,
    input wire logic [2:0]  ref_select,
    input wire logic [11:0] output_force_mask
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    zd_write_a: assert property (reg_wr && reg_addr == 16'h0487 |=> ##1
        zero_delay_operation == $past(reg_wdata[0], 2)) else $error("enable not followed");
    fb_open_a: assert property (internal_feedback_open == zero_delay_operation)
        else $error("feedback path state wrong");
    no_hitless_a: assert property (hitless_switch_allow == !zero_delay_operation)
        else $error("hitless allowed in zero-delay");
    auto_gov_a: assert property (auto_input_switch_enable |=> governing_source == 2'h3)
        else $error("auto engine not governing");
    force_fb_a: assert property (feedback_output_force == output_force_mask[11])
        else $error("feedback force mismatch");
    sel_onehot_a: assert property (ref_select_valid |-> $onehot(ref_select))
        else $error("select not one-hot");
    sel_none_a: assert property (!ref_select_valid |-> ref_select == 3'h0)
        else $error("invalid choice selects input");
    pins_gov_a: assert property (governing_source == 2'h0 && ref_select_valid |->
        ref_select == 3'h1 << $past({input_choice_pin_hi, input_choice_pin_lo}))
        else $error("pin choice not applied");
    cover property (zero_delay_operation && governing_source == 2'h2);
    cover property (!ref_select_valid);
    cover property (governing_source == 2'h3);
endmodule

// File: test/zdis_select_drv.sv
`timescale 1ns/100ps
// select pins, normal select register and auto engine, moved off the rising edge
module zdis_select_drv (
    input  logic       clk_sys,
    input  logic [6:0] cmd,
    output logic       pin_hi, pin_lo, auto_en,
    output logic [1:0] norm, auto_sel
);
    always @(negedge clk_sys)
        {pin_hi, pin_lo, norm, auto_en, auto_sel} <= cmd;
endmodule

// File: test/zero_delay_input_select_tb.sv
`timescale 1ns/100ps
module zero_delay_input_select_tb;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, ph, pl, ae, zo, fo, ha, sv, ff;
    logic [15:0] reg_addr = 0;
    logic [7:0]  reg_wdata = 0, rdata;
    logic [6:0]  cmd = 0;
    logic [1:0]  nc, ac, gs;
    logic [2:0]  rs;
    logic [11:0] fm;
    int fail_count = 0, n_tests = 0, s;
    always #12.5 clk_sys = ~clk_sys;
    zdis_select_drv i_drv (.clk_sys(clk_sys), .cmd(cmd), .pin_hi(ph), .pin_lo(pl),
        .auto_en(ae), .norm(nc), .auto_sel(ac));
    zdis_top i_dut (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
        .input_choice_pin_hi(ph), .input_choice_pin_lo(pl), .normal_input_choice(nc),
        .auto_input_switch_enable(ae), .auto_input_choice(ac), .zero_delay_operation(zo),
        .internal_feedback_open(fo), .hitless_switch_allow(ha), .ref_select(rs),
        .ref_select_valid(sv), .governing_source(gs), .feedback_output_force(ff),
        .output_force_mask(fm));
    task chk(input string nm, input [11:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        @(negedge clk_sys); reg_wr = 1; reg_addr = a; reg_wdata = d;
        @(negedge clk_sys); reg_wr = 0;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        @(negedge clk_sys); reg_rd = 1; reg_addr = a;
        @(negedge clk_sys); reg_rd = 0;
        chk("rdata", rdata, e);
    endtask
    task st;
        repeat (2) @(negedge clk_sys);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #1000000 fail_count++;
        give_verdict;
    end
    initial
    begin
        repeat (2) @(negedge clk_sys); reset = 0;
        // reset values, unmapped address reads zero
        rd(16'h013F, 8'h00); rd(16'h0140, 8'h00); rd(16'h0487, 8'h00);
        rd(16'h052A, 8'h00); rd(16'h0001, 8'h00);
        chk("ref_select", rs, 3'h1); chk("zero_delay", zo, 1'h0);
        chk("valid", sv, 1'h1);
        $display("test reset done");
        // zero-delay with pin control
        wr(16'h0487, 8'h01); cmd = 7'b1000000; st;
        chk("zero_delay", zo, 1'h1); chk("fb_open", fo, 1'h1);
        chk("hitless", ha, 1'h0); chk("gov", gs, 2'h0); chk("ref_select", rs, 3'h4);
        $display("test pins done");
        // register control, every field code, normal choice ignored
        wr(16'h052A, 8'h01); cmd = 7'b1001000;
        for (s = 0; s < 4; s++)
        begin
            wr(16'h0487, 8'(s * 2 + 1)); st;
            chk("gov", gs, 2'h2);
            chk("ref_select", rs, s < 3 ? 3'h1 << s : 3'h0);
            chk("valid", sv, s < 3 ? 12'h001 : 12'h000);
            rd(16'h0487, 8'(s * 2 + 1));
        end
        wr(16'h0487, 8'h00); st;
        chk("gov", gs, 2'h1); chk("zero_delay", zo, 1'h0);
        cmd = 7'b1001101; st;
        chk("gov", gs, 2'h3); chk("ref_select", rs, 3'h2);
        $display("test select done");
        // force field, reserved high bits
        wr(16'h013F, 8'h00); wr(16'h0140, 8'hFF); st;
        chk("mask", fm, 12'hF00); rd(16'h0140, 8'h0F);
        wr(16'h0140, 8'h08); st;
        chk("mask", fm, 12'h800); chk("force", ff, 1'h1);
        wr(16'h0140, 8'h00); st;
        chk("force", ff, 1'h0);
        $display("test force done");
        give_verdict;
    end
endmodule
bind zdis_top zdis_props i_props (.*);
